// [src/cmp_control.sv]
/*
  Digital control for two analog comparators with an APB register file.
  Assumes raw compare results are synchronous to clock, and that the
  timer source clock arrives as a one-cycle pulse per half period.
*/
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cmp_control
  import cmp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [1:0]        raw_result,
  input  wire logic              timer_src_tick,
  output logic [1:0]             cmp_result_mirror,
  output logic [1:0]             gate_out,
  output logic [1:0]             pin_out,
  output logic [1:0]             cmp_irq_flag,
  output logic [1:0]             hysteresis_on,
  output logic [1:0]             analog_on,
  output logic [2*PSW_W-1:0]     pos_switch_r,
  output logic [2*NSW_W-1:0]     neg_switch_r,
  output logic                   timer_count_tick
);
  logic [7:0] ctrl0_r [2];
  logic [7:0] ctrl1_r [2];
  logic [2:0] nsel_r  [2];
  logic [2:0] psel_r  [2];
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic [PRESC_W-1:0] presc_r;
  logic [1:0] result;
  logic [1:0] ext_out;
  logic [1:0] edge_hit;
  logic [PSW_W-1:0] psw [2];
  logic [NSW_W-1:0] nsw [2];
  logic       fall_tick;
  logic       rise_tick;

  // APB decode: zero wait states, unmapped reads zero with an error
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic [31:0] rd_mux;
  logic [1:0] flag_clear;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit = (paddr == OFF_CTRL_ZERO_1) || (paddr == OFF_CTRL_ONE_1)
            || (paddr == OFF_NEG_SEL_1)   || (paddr == OFF_POS_SEL_1)
            || (paddr == OFF_CTRL_ZERO_2) || (paddr == OFF_CTRL_ONE_2)
            || (paddr == OFF_NEG_SEL_2)   || (paddr == OFF_POS_SEL_2)
            || (paddr == OFF_MIRROR)      || (paddr == OFF_FLAGS)
            || (paddr == OFF_TIMER_CFG);

  // Status fields inserted live; unused bits read zero
  function automatic logic [31:0] ctrl0_view(input logic [7:0] c,
                                             input logic       r);
    logic [31:0] v;
    v = ZERO_WORD;
    v[BIT_ENABLE] = c[BIT_ENABLE];
    v[BIT_RESULT] = r;
    v[BIT_INVERT] = c[BIT_INVERT];
    v[BIT_HYST]   = c[BIT_HYST];
    v[BIT_SYNC]   = c[BIT_SYNC];
    return v;
  endfunction : ctrl0_view

  // Read selection
  always_comb begin
    rd_mux = ZERO_WORD;
    case (paddr)
      OFF_CTRL_ZERO_1: rd_mux = ctrl0_view(ctrl0_r[0], result[0]);
      OFF_CTRL_ONE_1:  rd_mux = {24'h00_0000, ctrl1_r[0]};
      OFF_NEG_SEL_1:   rd_mux = {29'h0000_0000, nsel_r[0]};
      OFF_POS_SEL_1:   rd_mux = {29'h0000_0000, psel_r[0]};
      OFF_CTRL_ZERO_2: rd_mux = ctrl0_view(ctrl0_r[1], result[1]);
      OFF_CTRL_ONE_2:  rd_mux = {24'h00_0000, ctrl1_r[1]};
      OFF_NEG_SEL_2:   rd_mux = {29'h0000_0000, nsel_r[1]};
      OFF_POS_SEL_2:   rd_mux = {29'h0000_0000, psel_r[1]};
      OFF_MIRROR:      rd_mux = {30'h0000_0000, result};
      OFF_FLAGS:       rd_mux = {30'h0000_0000, flag_r};
      OFF_TIMER_CFG:   rd_mux = {30'h0000_0000, presc_r};
      default:         rd_mux = ZERO_WORD;
    endcase
  end

  // Write one to clear a flag, but a new edge wins
  assign flag_clear = (wr_en && paddr == OFF_FLAGS) ? pwdata[1:0] : 2'b00;
  assign flag_nxt   = (flag_r & ~flag_clear) | edge_hit;

  // Registers; control register zero keeps its whole written byte, the others only their listed bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl0_r[i] <= RST_BYTE;
        ctrl1_r[i] <= RST_BYTE;
        nsel_r[i]  <= 3'h0;
        psel_r[i]  <= 3'h0;
      end
      presc_r <= '0;
      flag_r  <= 2'b00;
    end else begin
      flag_r <= flag_nxt;
      if (wr_en) begin
        case (paddr)
          OFF_CTRL_ZERO_1: ctrl0_r[0] <= pwdata[7:0];
          OFF_CTRL_ONE_1:  ctrl1_r[0] <= {6'h00, pwdata[1:0]};
          OFF_NEG_SEL_1:   nsel_r[0]  <= pwdata[2:0];
          OFF_POS_SEL_1:   psel_r[0]  <= pwdata[2:0];
          OFF_CTRL_ZERO_2: ctrl0_r[1] <= pwdata[7:0];
          OFF_CTRL_ONE_2:  ctrl1_r[1] <= {6'h00, pwdata[1:0]};
          OFF_NEG_SEL_2:   nsel_r[1]  <= pwdata[2:0];
          OFF_POS_SEL_2:   psel_r[1]  <= pwdata[2:0];
          OFF_TIMER_CFG:   presc_r    <= pwdata[PRESC_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // APB answer: ready during every access phase, data from setup
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= ZERO_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) prdata <= rd_mux;
    end
  end

  cmp_timer_tick u_tick (
    .clock           (clock),
    .resetn          (resetn),
    .timer_src_tick  (timer_src_tick),
    .presc_sel       (presc_r),
    .fall_tick       (fall_tick),
    .timer_rise_tick (rise_tick)
  );

  // Two comparator channels
  for (genvar g = 0; g < 2; g++) begin : g_ch
    cmp_channel u_ch (
      .clock             (clock),
      .resetn            (resetn),
      .raw_result        (raw_result[g]),
      .cmp_enable        (ctrl0_r[g][BIT_ENABLE]),
      .cmp_invert        (ctrl0_r[g][BIT_INVERT]),
      .cmp_sync_to_timer (ctrl0_r[g][BIT_SYNC]),
      .rise_irq_en       (ctrl1_r[g][BIT_RISE_EN]),
      .fall_irq_en       (ctrl1_r[g][BIT_FALL_EN]),
      .timer_fall_tick   (fall_tick),
      .pos_input_sel     (psel_r[g]),
      .neg_input_sel     (nsel_r[g]),
      .result_r          (result[g]),
      .ext_out_r         (ext_out[g]),
      .edge_event        (edge_hit[g]),
      .pos_switch        (psw[g]),
      .neg_switch        (nsw[g])
    );
  end

  // Outputs registered; gate and pin share the same (optionally synced)
  // path, the pin router and pin direction live outside this block
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmp_result_mirror <= 2'b00;
      gate_out          <= 2'b00;
      pin_out           <= 2'b00;
      cmp_irq_flag      <= 2'b00;
      hysteresis_on     <= 2'b00;
      analog_on         <= 2'b00;
      pos_switch_r      <= '0;
      neg_switch_r      <= '0;
      timer_count_tick  <= 1'b0;
    end else begin
      cmp_result_mirror <= result;
      gate_out          <= ext_out;
      pin_out           <= ext_out;
      cmp_irq_flag      <= flag_nxt;
      hysteresis_on     <= {ctrl0_r[1][BIT_HYST] & ctrl0_r[1][BIT_ENABLE],
                            ctrl0_r[0][BIT_HYST] & ctrl0_r[0][BIT_ENABLE]};
      analog_on         <= {ctrl0_r[1][BIT_ENABLE], ctrl0_r[0][BIT_ENABLE]};
      pos_switch_r      <= {psw[1], psw[0]};
      neg_switch_r      <= {nsw[1], nsw[0]};
      timer_count_tick  <= rise_tick;
    end
  end

  // Flag checks: set wins, only software clears, exported copy in step
  a_flag_sticky: assert property (
    @(posedge clock) disable iff (!resetn)
    (flag_r[0] && flag_clear[0] == 1'b0) |=> flag_r[0])
    else $error("flag cleared without software");
  a_flag_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    (flag_clear[0] && !edge_hit[0]) |=> !flag_r[0])
    else $error("flag not cleared by software");
  a_set_wins: assert property (
    @(posedge clock) disable iff (!resetn)
    edge_hit[0] |=> flag_r[0])
    else $error("edge lost against clear");
  a_irq_copy: assert property (
    @(posedge clock) disable iff (!resetn)
    1'b1 |=> cmp_irq_flag == flag_r)
    else $error("flag output out of step");
  a_mirror_bits: assert property (
    @(posedge clock) disable iff (!resetn)
    1'b1 |=> cmp_result_mirror == $past(result))
    else $error("mirror out of step");
  // Power follows the enable bit of comparator one, hysteresis its hysteresis bit while enabled
  a_power_off: assert property (
    @(posedge clock) disable iff (!resetn)
    !ctrl0_r[0][BIT_ENABLE] |=> !analog_on[0])
    else $error("analog powered while disabled");
  a_hyst_off: assert property (
    @(posedge clock) disable iff (!resetn)
    !ctrl0_r[0][BIT_HYST] |=> !hysteresis_on[0])
    else $error("hysteresis on while bit clear");
  a_no_tick_clash: assert property (
    @(posedge clock) disable iff (!resetn)
    !(fall_tick && rise_tick))
    else $error("latch and count on one edge");
  a_apb_ready: assert property (
    @(posedge clock) disable iff (!resetn)
    (psel && !penable) |=> pready)
    else $error("no ready after setup");
  c_flag_set: cover property (@(posedge clock) disable iff (!resetn)
    $rose(flag_r[0]));
  c_clear_race: cover property (@(posedge clock) disable iff (!resetn)
    edge_hit[0] && flag_clear[0]);
  c_sync_tick: cover property (@(posedge clock) disable iff (!resetn)
    fall_tick);
endmodule : cmp_control

// [src/cmp_pkg.sv]
/*
  Constants shared by the comparator control logic: register offsets,
  field positions, reset values and input select codes.
  Assumes an APB master with 32-bit data and word-aligned registers.
*/
package cmp_pkg;
  // Byte offsets of the registers (one aligned word each)
  localparam logic [11:0] OFF_CTRL_ZERO_1  = 12'h000;
  localparam logic [11:0] OFF_CTRL_ONE_1   = 12'h004;
  localparam logic [11:0] OFF_NEG_SEL_1    = 12'h008;
  localparam logic [11:0] OFF_POS_SEL_1    = 12'h00C;
  localparam logic [11:0] OFF_CTRL_ZERO_2  = 12'h010;
  localparam logic [11:0] OFF_CTRL_ONE_2   = 12'h014;
  localparam logic [11:0] OFF_NEG_SEL_2    = 12'h018;
  localparam logic [11:0] OFF_POS_SEL_2    = 12'h01C;
  localparam logic [11:0] OFF_MIRROR       = 12'h020;
  localparam logic [11:0] OFF_FLAGS        = 12'h024;
  localparam logic [11:0] OFF_TIMER_CFG    = 12'h028;
  // Control register zero fields
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_RESULT    = 6;
  localparam int BIT_INVERT    = 4;
  localparam int BIT_HYST      = 1;
  localparam int BIT_SYNC      = 0;
  // Control register one fields
  localparam int BIT_RISE_EN   = 1;
  localparam int BIT_FALL_EN   = 0;
  // Mirror / flag bit positions
  localparam int BIT_CMP_ONE   = 0;
  localparam int BIT_CMP_TWO   = 1;
  // Timer config: prescaler select width
  localparam int PRESC_W       = 2;
  localparam int SEL_W         = 3;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  // Positive select codes
  localparam logic [2:0] PSEL_PIN0 = 3'h0;
  localparam logic [2:0] PSEL_PIN1 = 3'h1;
  localparam logic [2:0] PSEL_DAC  = 3'h5;
  localparam logic [2:0] PSEL_REF  = 3'h6;
  localparam logic [2:0] PSEL_GND  = 3'h7;
  // Negative select codes
  localparam logic [2:0] NSEL_PIN3 = 3'h3;
  localparam logic [2:0] NSEL_REF  = 3'h6;
  localparam logic [2:0] NSEL_GND  = 3'h7;
  // One-hot analog switch layout
  localparam int PSW_W = 5;  // pin0, pin1, dac, ref, gnd
  localparam int NSW_W = 6;  // pin0..pin3, ref, gnd
endpackage : cmp_pkg

// [src/cmp_channel.sv]
/*
  One comparator channel: enable and polarity gating, per-cycle latch,
  optional falling-edge timer synchronisation, edge detectors and the
  input switch decode. Assumes timer clock edges arrive as one-cycle
  enable pulses already taken after the prescaler.
*/
`timescale 1ns/1ps
module cmp_channel
  import cmp_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             raw_result,
  input  wire logic             cmp_enable,
  input  wire logic             cmp_invert,
  input  wire logic             cmp_sync_to_timer,
  input  wire logic             rise_irq_en,
  input  wire logic             fall_irq_en,
  input  wire logic             timer_fall_tick,
  input  wire logic [SEL_W-1:0] pos_input_sel,
  input  wire logic [SEL_W-1:0] neg_input_sel,
  output logic                  result_r,
  output logic                  ext_out_r,
  output logic                  edge_event,
  output logic [PSW_W-1:0]      pos_switch,
  output logic [NSW_W-1:0]      neg_switch
);
  logic gated;
  logic prev_r;
  logic sync_r;
  logic ext_nxt;

  // Disabled comparator reads the invert bit; invert after gating so toggling the
  // polarity or enable of an idle comparator still makes an edge
  assign gated = (cmp_enable & raw_result) ^ cmp_invert;

  // Latch once per instruction cycle, remember previous for edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      result_r <= gated;
      prev_r   <= result_r;
    end
  end

  // Edge hits filtered by their enables, one cycle wide
  assign edge_event = (rise_irq_en & result_r & ~prev_r)
                    | (fall_irq_en & ~result_r & prev_r);

  // Timer-side copy updated only on falling edges of the divided clock,
  // so it never moves on the edge where the timer counts
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_r <= 1'b0;
    end else if (timer_fall_tick) begin
      sync_r <= gated;
    end
  end

  // Unsynchronised path follows the comparator directly (one flop for
  // a registered output only)
  assign ext_nxt = cmp_sync_to_timer ? sync_r : gated;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_out_r <= 1'b0;
    end else begin
      ext_out_r <= ext_nxt;
    end
  end

  // Analog switch decode; every switch opens while disabled
  assign pos_switch = !cmp_enable ? '0 :
    (pos_input_sel == PSEL_PIN0) ? 5'b00001 :
    (pos_input_sel == PSEL_PIN1) ? 5'b00010 :
    (pos_input_sel == PSEL_DAC)  ? 5'b00100 :
    (pos_input_sel == PSEL_REF)  ? 5'b01000 :
    (pos_input_sel == PSEL_GND)  ? 5'b10000 : '0;
  assign neg_switch = !cmp_enable ? '0 :
    (neg_input_sel <= NSEL_PIN3) ? (6'b000001 << neg_input_sel) :
    (neg_input_sel == NSEL_REF)  ? 6'b010000 :
    (neg_input_sel == NSEL_GND)  ? 6'b100000 : '0;

  a_disabled_quiet: assert property (
    @(posedge clock) disable iff (!resetn)
    !cmp_enable |-> (pos_switch == '0) && (neg_switch == '0))
    else $error("switch closed while disabled");
  a_latch_follows: assert property (
    @(posedge clock) disable iff (!resetn)
    1'b1 |=> result_r == $past(gated))
    else $error("result not latched");
  a_rise_event: assert property (
    @(posedge clock) disable iff (!resetn)
    (rise_irq_en && $rose(result_r)) |-> edge_event)
    else $error("rise edge missed");
  a_fall_event: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall_irq_en && $fell(result_r)) |-> edge_event)
    else $error("fall edge missed");
  a_sync_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    !timer_fall_tick |=> $stable(sync_r))
    else $error("sync copy moved off tick");
  c_rise: cover property (@(posedge clock) disable iff (!resetn)
    $rose(result_r));
  c_sync_out: cover property (@(posedge clock) disable iff (!resetn)
    cmp_sync_to_timer && timer_fall_tick && $changed(gated));
endmodule : cmp_channel

// [src/cmp_timer_tick.sv]
/*
  Timer clock prescaler for the synchronisation path. Produces a
  one-cycle pulse on each falling edge of the divided timer clock.
  Assumes timer_src_tick is a one-cycle pulse per source clock half period.
*/
`timescale 1ns/1ps
module cmp_timer_tick
  import cmp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               timer_src_tick,
  input  wire logic [PRESC_W-1:0] presc_sel,
  output logic                    fall_tick,
  output logic                    timer_rise_tick
);
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [7:0] half;
  logic       wrap;

  // Each source tick is one half period of the source clock, so the
  // prescaled clock toggles every 2^presc_sel ticks
  assign half    = 8'h01 << presc_sel;
  assign wrap    = timer_src_tick && (div_r == half - 8'h01);
  assign div_nxt = wrap ? 8'h00 : div_r + 8'h01;

  logic phase_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_r   <= 8'h00;
      phase_r <= 1'b0;
    end else if (timer_src_tick) begin
      div_r   <= div_nxt;
      if (wrap) phase_r <= ~phase_r;
    end
  end

  // Falling edge of prescaled clock latches, rising edge counts
  assign fall_tick       = wrap && phase_r;
  assign timer_rise_tick = wrap && !phase_r;
endmodule : cmp_timer_tick

// [verification/cmp_analog_model.sv]
/*
  Behavioural model of the analog comparator cores and of the timer
  clock source that stand beside the control block.
  Assumes the bench supplies source levels as unsigned 8-bit values.
*/
`timescale 1ns/1ps
module cmp_analog_model
  import cmp_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic [2*PSW_W-1:0]   pos_switch_r,
  input  wire logic [2*NSW_W-1:0]   neg_switch_r,
  input  wire logic [1:0]           analog_on,
  input  wire logic [8*PSW_W-1:0]   plus_lvl,
  input  wire logic [8*NSW_W-1:0]   minus_lvl,
  input  wire logic                 tick_en,
  output logic      [1:0]           raw_result,
  output logic                      timer_src_tick
);
  logic [1:0] tick_cnt_r;

  // Open switches leave the node at zero, so an unconnected input loses
  function automatic logic [7:0] pick(input logic [NSW_W-1:0] sw,
                                      input logic [8*NSW_W-1:0] lv);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < NSW_W; i++) begin
      if (sw[i]) v = v | lv[8*i +: 8];
    end
    return v;
  endfunction : pick

  // Raw result registered, as the block expects it synchronous to clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      raw_result <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        raw_result[c] <= analog_on[c] &
          (pick({1'b0, pos_switch_r[PSW_W*c +: PSW_W]}, {8'h00, plus_lvl})
           > pick(neg_switch_r[NSW_W*c +: NSW_W], minus_lvl));
      end
    end
  end

  // Source clock half period of four cycles, frozen when not enabled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r     <= 2'b00;
      timer_src_tick <= 1'b0;
    end else begin
      tick_cnt_r     <= tick_cnt_r + 2'b01;
      timer_src_tick <= tick_en & (tick_cnt_r == 2'b11);
    end
  end
endmodule : cmp_analog_model

// [verification/comparator_digital_control_tb.sv]
/*
  Self-checking bench for the comparator control block.
  Assumes the analog model above and a wait-free APB slave.
*/
`timescale 1ns/1ps
module comparator_digital_control_tb
  import cmp_pkg::*;
;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic        err, tick_en, timer_src_tick, timer_count_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  raw_result, mirror, gate_out, pin_out, irq_flag;
  logic [1:0]  hyst_on, analog_on;
  logic [9:0]  pos_sw;
  logic [11:0] neg_sw;
  logic [39:0] plus_lvl;
  logic [47:0] minus_lvl;
  int          n_fail, num_checks, cyc;

  cmp_control dut (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .raw_result(raw_result), .timer_src_tick(timer_src_tick),
    .cmp_result_mirror(mirror), .gate_out(gate_out), .pin_out(pin_out),
    .cmp_irq_flag(irq_flag), .hysteresis_on(hyst_on),
    .analog_on(analog_on), .pos_switch_r(pos_sw), .neg_switch_r(neg_sw),
    .timer_count_tick(timer_count_tick));

  cmp_analog_model core (.clock(clock), .resetn(resetn),
    .pos_switch_r(pos_sw), .neg_switch_r(neg_sw), .analog_on(analog_on),
    .plus_lvl(plus_lvl), .minus_lvl(minus_lvl), .tick_en(tick_en),
    .raw_result(raw_result), .timer_src_tick(timer_src_tick));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Cuts a hang short; the whole run needs well under this
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Plus level on every connectable source except ground
  task automatic lv(input logic [7:0] p);
    plus_lvl <= {8'h00, {4{p}}};
    repeat (6) @(posedge clock);
  endtask : lv

  task automatic t_regs();
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, 12'(4 * i), ZERO_WORD);
      chk("reset value", rd, ZERO_WORD);
    end
    apb(1'b0, 12'h02C, ZERO_WORD);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, OFF_CTRL_ONE_1, 32'hFFFF_FFFF);
    apb(1'b0, OFF_CTRL_ONE_1, ZERO_WORD);
    chk("ctrl one width", rd, 32'h0000_0003);
    apb(1'b1, OFF_MIRROR, 32'hFFFF_FFFF);
    apb(1'b0, OFF_MIRROR, ZERO_WORD);
    chk("mirror read only", rd, ZERO_WORD);
    apb(1'b1, OFF_CTRL_ONE_1, ZERO_WORD);
  endtask : t_regs

  task automatic t_polarity();
    logic e;
    for (int inv = 0; inv < 2; inv++) begin
      for (int hi = 0; hi < 2; hi++) begin
        apb(1'b1, OFF_CTRL_ZERO_1, {24'h0, 3'b100, 1'(inv), 4'h0});
        apb(1'b1, OFF_CTRL_ZERO_2, {24'h0, 3'b100, 1'(inv), 4'h0});
        lv(hi != 0 ? 8'h80 : 8'h40);
        e = 1'(hi ^ inv);
        chk("mirror port", {30'h0, mirror}, {30'h0, e, e});
        apb(1'b0, OFF_CTRL_ZERO_2, ZERO_WORD);
        chk("ctrl zero", rd, {24'h0, 1'b1, e, 1'b0, 1'(inv), 4'h0});
        apb(1'b0, OFF_MIRROR, ZERO_WORD);
        chk("mirror reg", rd, {30'h0, e, e});
      end
    end
  endtask : t_polarity

  task automatic t_select();
    logic [4:0] ep;
    logic [5:0] en;
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0082);
    apb(1'b1, OFF_CTRL_ZERO_2, 32'h0000_0002);
    repeat (3) @(posedge clock);
    chk("hysteresis", {30'h0, hyst_on}, 32'h0000_0001);
    chk("power", {30'h0, analog_on}, 32'h0000_0001);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, OFF_POS_SEL_1, 32'(c));
      apb(1'b1, OFF_NEG_SEL_1, 32'(c));
      repeat (3) @(posedge clock);
      ep = (c < 2) ? 5'(1 << c) : (c > 4) ? 5'(1 << (c - 3)) : 5'h00;
      en = (c < 4) ? 6'(1 << c) : (c > 5) ? 6'(1 << (c - 2)) : 6'h00;
      chk("plus switch", {27'h0, pos_sw[4:0]}, {27'h0, ep});
      chk("minus switch", {26'h0, neg_sw[5:0]}, {26'h0, en});
      apb(1'b0, OFF_NEG_SEL_1, ZERO_WORD);
      chk("select read", rd, 32'(c));
    end
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0002);
    repeat (3) @(posedge clock);
    chk("off switches", {21'h0, neg_sw[5:0], pos_sw[4:0]}, ZERO_WORD);
    apb(1'b1, OFF_POS_SEL_1, ZERO_WORD);
    apb(1'b1, OFF_NEG_SEL_1, ZERO_WORD);
  endtask : t_select

  task automatic t_edge();
    lv(8'h40);
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0080);
    apb(1'b1, OFF_CTRL_ONE_1, 32'h0000_0002);
    lv(8'h40);
    apb(1'b1, OFF_FLAGS, 32'h0000_0003);
    lv(8'h80);
    chk("rise flag", {31'h0, irq_flag[0]}, 32'h0000_0001);
    repeat (20) @(posedge clock);
    apb(1'b0, OFF_FLAGS, ZERO_WORD);
    chk("flag sticky", rd, 32'h0000_0001);
    apb(1'b1, OFF_FLAGS, 32'h0000_0001);
    lv(8'h40);
    chk("fall ignored", {31'h0, irq_flag[0]}, ZERO_WORD);
    apb(1'b1, OFF_CTRL_ONE_1, 32'h0000_0001);
    lv(8'h80);
    chk("rise ignored", {31'h0, irq_flag[0]}, ZERO_WORD);
    lv(8'h40);
    chk("fall flag", {31'h0, irq_flag[0]}, 32'h0000_0001);
  endtask : t_edge

  // Clear write lands on the very edge that sees a new rise
  task automatic t_race();
    apb(1'b1, OFF_CTRL_ONE_1, 32'h0000_0003);
    plus_lvl <= {8'h00, {4{8'h80}}};
    apb(1'b1, OFF_FLAGS, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk("set wins", {31'h0, irq_flag[0]}, 32'h0000_0001);
  endtask : t_race

  task automatic t_disabled();
    apb(1'b1, OFF_CTRL_ONE_1, 32'h0000_0003);
    apb(1'b1, OFF_CTRL_ZERO_1, ZERO_WORD);
    lv(8'h80);
    apb(1'b1, OFF_FLAGS, 32'h0000_0003);
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0010);
    repeat (6) @(posedge clock);
    chk("invert edge", {30'h0, irq_flag}, 32'h0000_0001);
    apb(1'b1, OFF_CTRL_ZERO_1, ZERO_WORD);
    apb(1'b1, OFF_FLAGS, 32'h0000_0003);
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0080);
    repeat (6) @(posedge clock);
    chk("enable edge", {30'h0, irq_flag}, 32'h0000_0001);
  endtask : t_disabled

  task automatic t_sync();
    int n;
    apb(1'b1, OFF_CTRL_ZERO_1, 32'h0000_0081);
    apb(1'b1, OFF_CTRL_ZERO_2, 32'h0000_0080);
    lv(8'h40);
    lv(8'h80);
    repeat (10) @(posedge clock);
    chk("latched out", {30'h0, mirror}, 32'h0000_0003);
    chk("gate held", {30'h0, gate_out}, 32'h0000_0002);
    chk("pin held", {30'h0, pin_out}, 32'h0000_0002);
    tick_en <= 1'b1;
    repeat (40) @(posedge clock);
    chk("gate follows", {30'h0, gate_out}, 32'h0000_0003);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFF_TIMER_CFG, 32'(p));
      n = 0;
      repeat (256) begin
        @(posedge clock);
        n += int'(timer_count_tick === 1'b1);
      end
      chk("presc rate", 32'(n >= (32 >> p) - 1 && n <= (32 >> p) + 1),
          32'h0000_0001);
    end
  endtask : t_sync

  // Main sequence: reset, then each scenario in turn
  initial begin
    resetn    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = ZERO_WORD;
    tick_en   = 1'b0;
    plus_lvl  = 40'h00_0000_0000;
    minus_lvl = {8'h00, {5{8'h60}}};
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_polarity();
    t_select();
    t_edge();
    t_race();
    t_disabled();
    t_sync();
    close_out();
  end
endmodule : comparator_digital_control_tb
